// [src/dmc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.svh"
module dmc_ctrl #(
  parameter int PAUSE_CYC   = `DMC_PAUSE_CYC,
  parameter int REF_INT_CYC = `DMC_REF_INT_CYC,
  parameter bit USE_CBR     = 1'b1
) (
  input  wire logic             I_CLK,
  input  wire logic             I_RESET_N,
  input  wire logic             i_req_valid,
  input  wire dmc_pkg::dmc_req_t i_req,
  input  wire logic             i_dout,
  output logic                  o_req_ready,
  output logic                  o_rd_valid,
  output logic                  o_rd_data,
  output logic                  o_init_done,
  output logic                  o_ras_n,
  output logic                  o_cas_n,
  output logic                  o_we_n,
  output logic [9:0]            o_addr,
  output logic                  o_din
);
  dmc_pkg::dmc_state_t state_ff;
  dmc_pkg::dmc_state_t nxt_state;
  dmc_pkg::dmc_req_t   req_ff;
  logic [15:0]         cnt_ff;
  logic [15:0]         ref_ff;
  logic [3:0]          init_ff;
  logic                ref_pend_ff;

  // row strobe low in these states
  function automatic logic ras_state(input dmc_pkg::dmc_state_t st);
    case (st)
      dmc_pkg::ST_ROW,
      dmc_pkg::ST_COL,
      dmc_pkg::ST_WRITE,
      dmc_pkg::ST_REF_RAS,
      dmc_pkg::ST_TEST_UP,
      dmc_pkg::ST_TEST_DN: ras_state = 1'b1;
      default:             ras_state = 1'b0;
    endcase
  endfunction

  // column strobe low; refresh drops it ahead of the row strobe
  function automatic logic cas_state(input dmc_pkg::dmc_state_t st);
    case (st)
      dmc_pkg::ST_COL,
      dmc_pkg::ST_WRITE,
      dmc_pkg::ST_REF_CAS,
      dmc_pkg::ST_REF_RAS,
      dmc_pkg::ST_TEST_DN: cas_state = 1'b1;
      default:             cas_state = 1'b0;
    endcase
  endfunction

  function automatic logic [9:0] row_of(input logic [19:0] a);
    row_of = a[19:10];
  endfunction

  function automatic logic [9:0] col_of(input logic [19:0] a);
    col_of = a[9:0];
  endfunction

  wire logic cnt_zero = (cnt_ff == 16'h0000);
  wire logic is_write = (req_ff.cmd == `DMC_CMD_WRITE);
  wire logic is_rmw   = (req_ff.cmd == `DMC_CMD_RMW);
  wire logic is_test  = (req_ff.cmd == `DMC_CMD_TEST);
  wire logic ref_due  = (ref_ff == 16'h0000);
  wire logic in_idle  = (state_ff == dmc_pkg::ST_IDLE);
  wire logic take     = o_req_ready & i_req_valid;
  wire logic take_req = in_idle & take & !ref_pend_ff;

  // next state: refresh outranks a waiting request
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dmc_pkg::ST_PAUSE:   if (cnt_zero) nxt_state = dmc_pkg::ST_INIT;
      dmc_pkg::ST_INIT:    if (cnt_zero) nxt_state = dmc_pkg::ST_IDLE;
      dmc_pkg::ST_IDLE: begin
        if (ref_pend_ff) nxt_state = dmc_pkg::ST_REF_CAS;
        else if (take && i_req.cmd == `DMC_CMD_TEST)
          nxt_state = dmc_pkg::ST_REF_CAS;
        else if (take) nxt_state = dmc_pkg::ST_ROW;
      end
      dmc_pkg::ST_ROW:     if (cnt_zero) nxt_state = dmc_pkg::ST_COL;
      dmc_pkg::ST_COL:     if (cnt_zero) nxt_state = is_rmw ?
                             dmc_pkg::ST_WRITE : dmc_pkg::ST_PRE;
      dmc_pkg::ST_WRITE:   if (cnt_zero) nxt_state = dmc_pkg::ST_PRE;
      dmc_pkg::ST_PRE:     if (cnt_zero) nxt_state = dmc_pkg::ST_IDLE;
      dmc_pkg::ST_REF_CAS: if (cnt_zero) nxt_state = dmc_pkg::ST_REF_RAS;
      // the test's own refresh also serves a pending one
      dmc_pkg::ST_REF_RAS: if (cnt_zero) nxt_state = is_test ?
                             dmc_pkg::ST_TEST_UP : dmc_pkg::ST_PRE;
      dmc_pkg::ST_TEST_UP: if (cnt_zero) nxt_state = dmc_pkg::ST_TEST_DN;
      dmc_pkg::ST_TEST_DN: if (cnt_zero) nxt_state = dmc_pkg::ST_WRITE;
      default:             nxt_state = dmc_pkg::ST_PAUSE;
    endcase
  end

  // dwell per state; test read waits the counter access time
  wire logic [15:0] dwell =
    (nxt_state == dmc_pkg::ST_INIT)    ? 16'(`DMC_PHASE_CYC * 2) :
    (nxt_state == dmc_pkg::ST_PRE)     ? 16'(`DMC_PRE_CYC) :
    (nxt_state == dmc_pkg::ST_TEST_DN) ?
      16'(`DMC_TEST_ACC_CYC + `DMC_PHASE_CYC) :
    16'(`DMC_PHASE_CYC);

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_ff    <= dmc_pkg::ST_PAUSE;
      cnt_ff      <= 16'(PAUSE_CYC);
      init_ff     <= 4'h0;
      o_init_done <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff)
        cnt_ff <= dwell;
      else if (!cnt_zero)
        cnt_ff <= cnt_ff - 16'h0001;
      // eight init cycles: row-only or column-before-row
      if (state_ff == dmc_pkg::ST_INIT && cnt_zero) begin
        init_ff <= init_ff + 4'h1;
        if (init_ff != 4'(`DMC_INIT_CYCLES - 1)) begin
          state_ff <= dmc_pkg::ST_INIT;
          cnt_ff   <= 16'(`DMC_PHASE_CYC * 2);
        end else
          o_init_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      ref_ff      <= 16'h0000;
      ref_pend_ff <= 1'b0;
    end else begin
      // one refresh slot per row interval covers 512 rows
      if (!o_init_done || ref_due)
        ref_ff <= 16'(REF_INT_CYC);
      else
        ref_ff <= ref_ff - 16'h0001;
      // a new interval wins over the clear
      if (ref_due && o_init_done)
        ref_pend_ff <= 1'b1;
      else if (state_ff == dmc_pkg::ST_REF_CAS)
        ref_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      req_ff      <= '0;
      o_req_ready <= 1'b0;
    end else begin
      if (take_req)
        req_ff <= i_req;
      else if (in_idle && ref_pend_ff)
        req_ff.cmd <= `DMC_CMD_READ;
      // no offer while a refresh is due, so a taken request is never lost
      o_req_ready <= (nxt_state == dmc_pkg::ST_IDLE) && o_init_done &&
                     !take_req && !ref_due && !ref_pend_ff;
    end
  end

  // sample at end of column phase (access time already met)
  wire logic rd_sample = cnt_zero && !is_write &&
                         ((state_ff == dmc_pkg::ST_COL) ||
                          (state_ff == dmc_pkg::ST_TEST_DN));

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      if (rd_sample) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= i_dout;
      end
    end
  end

  // init: column strobe leads the row strobe by one cycle
  wire logic init_run = (nxt_state == dmc_pkg::ST_INIT) &&
                        (state_ff == dmc_pkg::ST_INIT);
  wire logic init_cas = init_run && (cnt_ff > 16'(`DMC_PHASE_CYC));
  wire logic init_ras = init_cas &&
                        (cnt_ff < 16'(`DMC_PHASE_CYC * 2));
  // row address settles a cycle before the row strobe falls
  wire logic row_wait = in_idle && (nxt_state == dmc_pkg::ST_ROW);
  // column goes out a cycle before the column strobe falls
  wire logic col_early = (state_ff == dmc_pkg::ST_ROW) &&
                         (cnt_ff == 16'h0001);
  wire logic nx_ras = (ras_state(nxt_state) && !row_wait) || init_ras;
  wire logic nx_cas = cas_state(nxt_state) ||
    (init_cas && USE_CBR);
  // early write for plain writes, late strobe for rmw/test
  wire logic nx_we = (is_write && ((nxt_state == dmc_pkg::ST_ROW) ||
    (nxt_state == dmc_pkg::ST_COL))) ||
    (nxt_state == dmc_pkg::ST_WRITE);
  wire logic [9:0] nx_addr =
    ((nxt_state == dmc_pkg::ST_ROW) && !col_early) ?
    row_of(req_ff.addr) : col_of(req_ff.addr);

  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      o_ras_n <= 1'b1;
      o_cas_n <= 1'b1;
      o_we_n  <= 1'b1;
      o_addr  <= 10'h000;
      o_din   <= 1'b0;
    end else begin
      o_ras_n <= !nx_ras;
      o_cas_n <= !nx_cas;
      o_we_n  <= !nx_we;
      o_addr  <= take_req ? row_of(i_req.addr) : nx_addr;
      // rmw and test write whatever bit the requester chose
      o_din   <= req_ff.wdata;
    end
  end
endmodule // dmc_ctrl
`default_nettype wire

// [include/dmc_regs.svh]
// Contract
// - 200us pause, then eight row-only cycles
// - counter use: eight column-before-row cycles instead
// - read keeps write strobe high after strobes
// - nibble cycles 40/60 ns, precharge 10 ns
// - refresh all 512 rows every 8.2 ms; code refreshes once per REF_INT_CYC+1 = 321 cycles, 8.2176 ms for 512 rows
// - counter verification procedure with 512 test cycles
// - allow 45 ns test access before sampling
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_CLK_NS        50
`define DMC_PAUSE_US      200
`define DMC_PAUSE_CYC     ((`DMC_PAUSE_US * 1000 + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_REF_US        8200
`define DMC_ROWS          512
`define DMC_REF_INT_CYC   ((`DMC_REF_US * 1000 / `DMC_ROWS) / `DMC_CLK_NS)
`define DMC_INIT_CYCLES   8
`define DMC_TEST_ACC_NS   45
`define DMC_TEST_ACC_CYC  ((`DMC_TEST_ACC_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_PHASE_CYC     3
`define DMC_PRE_CYC       2
`define DMC_CMD_READ      2'h0
`define DMC_CMD_WRITE     2'h1
`define DMC_CMD_RMW       2'h2
`define DMC_CMD_TEST      2'h3
`endif

// [include/dmc_pkg.sv]
package dmc_pkg;
  typedef struct packed {
    logic [1:0]  cmd;
    logic [19:0] addr;
    logic        wdata;
  } dmc_req_t;
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dmc_strobe_t;
  typedef enum logic [3:0] {
    ST_PAUSE   = 4'h0,
    ST_INIT    = 4'h1,
    ST_IDLE    = 4'h2,
    ST_ROW     = 4'h3,
    ST_COL     = 4'h4,
    ST_WRITE   = 4'h5,
    ST_PRE     = 4'h6,
    ST_REF_CAS = 4'h7,
    ST_REF_RAS = 4'h8,
    ST_TEST_UP = 4'h9,
    ST_TEST_DN = 4'hA
  } dmc_state_t;
endpackage

// [verification/dmc_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl_sva #(
  parameter int PAUSE_CYC   = 4000,
  parameter int REF_INT_CYC = 320
) (
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  input wire logic       o_req_ready,
  input wire logic       o_rd_valid,
  input wire logic       o_init_done,
  input wire logic       o_ras_n,
  input wire logic       o_cas_n,
  input wire logic       o_we_n,
  input wire logic [9:0] o_addr
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  int cyc_ff;
  int gap_ff;
  int cbr_ff;
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      cyc_ff <= 0;
      gap_ff <= 0;
      cbr_ff <= 0;
    end else begin
      if (cyc_ff < PAUSE_CYC)
        cyc_ff <= cyc_ff + 1;
      if ($fell(o_ras_n) && !o_cas_n) begin
        gap_ff <= 0;
        cbr_ff <= cbr_ff + 1;
      end else if (o_init_done)
        gap_ff <= gap_ff + 1;
    end
  end
  a_pause_high: assert property (cyc_ff < PAUSE_CYC |-> o_ras_n && o_cas_n)
    else $error("strobe active during pause");
  a_init_cbr: assert property ($rose(o_init_done) |-> cbr_ff >= 8)
    else $error("init done before eight refreshes");
  a_ready_init: assert property (o_req_ready |-> o_init_done)
    else $error("ready before init");
  a_read_we_hold: assert property ($rose(o_cas_n) && $past(o_we_n) |-> o_we_n)
    else $error("write strobe dropped at column end");
  a_col_width: assert property ($fell(o_cas_n) |=> !o_cas_n)
    else $error("column strobe pulse too short");
  a_test_access: assert property ($fell(o_cas_n) |-> !o_rd_valid ##1 !o_rd_valid)
    else $error("data sampled too soon");
  // slack covers a refresh held back by one access
  a_refresh_gap: assert property (gap_ff <= REF_INT_CYC + 40)
    else $error("refresh overdue");
  a_col_addr_set: assert property ($fell(o_cas_n) && !o_ras_n |-> $stable(o_addr))
    else $error("address moved at column strobe");
endmodule // dmc_ctrl_sva
`default_nettype wire

// [verification/dmc_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dmc_dram_model (
  input  wire logic       i_ras_n,
  input  wire logic       i_cas_n,
  input  wire logic       i_we_n,
  input  wire logic [9:0] i_addr,
  input  wire logic       i_din,
  output logic            o_dout
);
  logic       mem [0:1048575];
  logic [9:0] row;
  logic [8:0] cnt = 9'h000;
  logic [19:0] a;
  initial o_dout = 1'b0;
  always @(negedge i_ras_n) begin
    row = !i_cas_n ? {1'b1, cnt} : i_addr;
    if (!i_cas_n)
      cnt = cnt + 9'h001;
  end
  always @(negedge i_cas_n) begin
    if (!i_ras_n) begin
      a = {row, i_addr};
      if (!i_we_n)
        mem[a] = i_din;
      else
        o_dout <= mem[a];
    end
  end
  always @(negedge i_we_n)
    if (!i_cas_n && !i_ras_n)
      mem[a] = i_din;
  // released output flips so a stale bit never passes; kept while low
  always @(posedge i_cas_n)
    o_dout <= ~o_dout;
endmodule // dmc_dram_model
`default_nettype wire

// [verification/test_dmc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.svh"
module test_dmc_ctrl;
  logic              I_CLK = 1'b0;
  logic              I_RESET_N = 1'b0;
  logic              req_valid = 1'b0;
  dmc_pkg::dmc_req_t req = '0;
  logic              ready, rd_valid, rd_data, init_done;
  logic              ras_n, cas_n, we_n, din, dout, got;
  logic [9:0]        addr;
  int                bad_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                ones;
  always #25 I_CLK = ~I_CLK;
  dmc_ctrl #(.PAUSE_CYC(20), .REF_INT_CYC(50)) u_dmc_ctrl (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_req_valid(req_valid),
    .i_req(req), .i_dout(dout), .o_req_ready(ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_init_done(init_done), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_din(din));
  dmc_dram_model u_dmc_dram_model (.i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_addr(addr), .i_din(din), .o_dout(dout));
  task automatic check(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(input logic [1:0] c, input logic [19:0] a,
                        input logic wd);
    req_valid <= 1'b1;
    req <= '{c, a, wd};
    do
      @(posedge I_CLK);
    while (ready !== 1'b1);
    req_valid <= 1'b0;
    if (c != `DMC_CMD_WRITE) begin
      while (rd_valid !== 1'b1) @(posedge I_CLK);
      got = rd_data;
    end
    @(posedge I_CLK);
  endtask
  task automatic t_init;
    while (init_done !== 1'b1) @(posedge I_CLK);
    check("init refreshes", u_dmc_dram_model.cnt === 9'h008, 1'b1);
  endtask
  task automatic t_rw_rmw;
    access(`DMC_CMD_WRITE, 20'hABCDE, 1'b1);
    access(`DMC_CMD_WRITE, 20'h12345, 1'b0);
    access(`DMC_CMD_READ, 20'hABCDE, 1'b0);
    check("read one", got, 1'b1);
    access(`DMC_CMD_READ, 20'h12345, 1'b1);
    check("read zero", got, 1'b0);
    access(`DMC_CMD_RMW, 20'hABCDE, 1'b0);
    check("rmw old", got, 1'b1);
    access(`DMC_CMD_READ, 20'hABCDE, 1'b1);
    check("rmw new", got, 1'b0);
  endtask
  task automatic t_counter;
    for (int r = 0; r < 512; r++)
      access(`DMC_CMD_WRITE, {1'b1, 9'(r), 10'h155}, 1'b0);
    repeat (2) begin
      access(`DMC_CMD_TEST, 20'h00155, 1'b1);
      check("test read", got, 1'b0);
    end
    ones = 0;
    for (int r = 0; r < 512; r++) begin
      access(`DMC_CMD_READ, {1'b1, 9'(r), 10'h155}, 1'b0);
      ones += (got === 1'b1);
    end
    check("test writes", ones == 2, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    t_init;
    t_rw_rmw;
    t_counter;
    complete_run;
  end
  // ceiling well above the roughly 16k cycles the sequence needs
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      complete_run;
    end
  end
endmodule // test_dmc_ctrl
bind dmc_ctrl dmc_ctrl_sva #(.PAUSE_CYC(PAUSE_CYC), .REF_INT_CYC(REF_INT_CYC))
  u_dmc_ctrl_sva (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
  .o_init_done(o_init_done), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
  .o_we_n(o_we_n), .o_addr(o_addr));
`default_nettype wire
